// >>> src/sap_host.sv
// sap_host: host side sequencer for an 18-bit sar converter with parallel read
// assumes converter pins are synchronous to CLK_SYS_I; data bus read as 18 inputs
`timescale 1ns/1ns
module sap_host
  import sap_pkg::*;
#(
  parameter int DATA_W = 18
) (
  // clock and reset
  input  wire logic              CLK_SYS_I,
  input  wire logic              RESET_I,
  // user request
  input  wire logic              START_I,
  input  wire logic              ABORT_I,
  input  wire sap_pkg::sap_fmt_t FORMAT_I,
  // user answer
  output logic [DATA_W-1:0]      RESULT_O,
  output logic                   RESULT_VALID_O,
  output logic                   READY_O,
  output logic                   ERROR_O,
  // converter pins
  output logic                   CONVERSION_START_N_O,
  output logic                   CS_N_O,
  output logic                   RD_N_O,
  output logic                   WORD_WIDTH_SELECT_O,
  output logic                   BYTE_SELECT_O,
  input  wire logic              BUSY_I,
  input  wire logic [DATA_W-1:0] DATA_I
);
  import sap_pkg::*;

  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    sap_state_t        state;
    logic              start_n;
    logic              cs_n;
    logic              rd_n;
    logic              wsel;
    logic              bsel;
    logic [1:0]        part;
    logic [DATA_W-1:0] result;
    logic              valid;
    logic              ready;
    logic              error;
    logic              busy_q;
    logic [CNT_W-1:0]  busy_cnt;
  } sap_regs_t;

  sap_regs_t r;
  sap_regs_t next_r;

  logic             tmr_load;
  logic [CNT_W-1:0] tmr_value;
  logic             tmr_done;
  logic [1:0]       last_part;
  logic             busy_fall;

  sap_timer #(
    .W (CNT_W)
  ) u_timer (
    .clk_i   (CLK_SYS_I),
    .rst_i   (RESET_I),
    .load_i  (tmr_load),
    .value_i (tmr_value),
    .done_o  (tmr_done)
  );

  // 18-bit mode takes one read, 16-bit two, 8-bit three
  always_comb begin
    unique case (FORMAT_I)
      SAP_FMT_16: last_part = 2'h1;
      SAP_FMT_8:  last_part = 2'h2;
      default:    last_part = 2'h0;
    endcase
  end

  assign busy_fall = r.busy_q && !BUSY_I;

  // ----------------------------------------
  // sequencer
  // ----------------------------------------
  always_comb begin
    next_r    = r;
    tmr_load  = 1'b0;
    tmr_value = '0;
    next_r.valid  = 1'b0;
    next_r.busy_q = BUSY_I;
    unique case (r.state)
      SAP_IDLE: begin
        next_r.ready = 1'b1;
        if (START_I) begin
          next_r.ready   = 1'b0;
          next_r.error   = 1'b0;
          next_r.start_n = 1'b0;
          next_r.cs_n    = 1'b1;
          next_r.state   = SAP_START;
          tmr_load       = 1'b1;
          tmr_value      = CNT_W'(CYC_START_LOW);
        end
      end
      SAP_START: begin
        // low time also covers the 40 ns no-touch window on the read pins
        if (tmr_done) begin
          next_r.start_n  = 1'b1;
          next_r.busy_cnt = '0;
          next_r.state    = SAP_WAITHI;
          tmr_load        = 1'b1;
          tmr_value       = CNT_W'(CYC_START_HIGH);
        end
      end
      SAP_WAITHI: begin
        // busy must already be up: rise is 40 ns, sample held in 25 ns
        if (!BUSY_I) begin
          next_r.error = 1'b1;
          next_r.state = SAP_ACQ;
          tmr_load     = 1'b1;
          tmr_value    = CNT_W'(CYC_ACQ);
        end else if (tmr_done) begin
          next_r.state = SAP_BUSY;
        end
      end
      SAP_BUSY: begin
        next_r.busy_cnt = r.busy_cnt + CNT_W'(1);
        // compared as int: the window start lies before the first busy count
        if (ABORT_I && (int'(r.busy_cnt) + CYC_BUSY_LEAD) >= CYC_ABORT_MIN &&
            (int'(r.busy_cnt) + CYC_BUSY_LEAD) <= CYC_ABORT_MAX) begin
          next_r.cs_n    = 1'b0;
          next_r.start_n = 1'b0;
          next_r.state   = SAP_START;
          tmr_load       = 1'b1;
          tmr_value      = CNT_W'(CYC_START_LOW);
        end else if (busy_fall) begin
          next_r.part  = 2'h0;
          next_r.wsel  = (FORMAT_I == SAP_FMT_18);
          next_r.bsel  = 1'b0;
          next_r.state = SAP_SETSEL;
          tmr_load     = 1'b1;
          // cs fall and read strobe kept clear of busy fall; selects change on the leaving edge
          tmr_value    = CNT_W'(CYC_CS_BUSY);
        end else if (r.busy_cnt == CNT_W'(CYC_CONV_MAX)) begin
          next_r.error = 1'b1;
          next_r.state = SAP_ACQ;
          tmr_load     = 1'b1;
          tmr_value    = CNT_W'(CYC_ACQ);
        end
      end
      SAP_SETSEL: begin
        if (tmr_done) begin
          next_r.cs_n  = 1'b0;
          next_r.rd_n  = 1'b0;
          next_r.state = SAP_RDLOW;
          tmr_load     = 1'b1;
          tmr_value    = CNT_W'(CYC_RD_LOW);
        end
      end
      SAP_RDLOW: begin
        if (tmr_done) begin
          // pieces arrive msb first; 8-bit reads shift in from the low end, 16-bit fills [17:2] then [1:0]
          unique case (FORMAT_I)
            SAP_FMT_16: next_r.result = (r.part == 2'h0) ? {DATA_I[15:0], 2'h0}
                                                         : {r.result[17:2], DATA_I[15:14]};
            SAP_FMT_8:  next_r.result = (r.part == 2'h2) ? {r.result[15:0], DATA_I[7:6]}
                                                         : {r.result[9:0], DATA_I[7:0]};
            default:    next_r.result = DATA_I;
          endcase
          next_r.rd_n  = 1'b1;
          next_r.state = SAP_RDHIGH;
          tmr_load     = 1'b1;
          tmr_value    = CNT_W'(CYC_RD_HIGH);
        end
      end
      SAP_RDHIGH: begin
        if (tmr_done) begin
          if (r.part == last_part) begin
            next_r.cs_n  = 1'b1;
            next_r.valid = 1'b1;
            next_r.state = SAP_ACQ;
            tmr_load     = 1'b1;
            tmr_value    = CNT_W'(CYC_ACQ);
          end else begin
            // 16-bit: second word via lane select; 8-bit: bytes via lane select
            next_r.part  = r.part + 2'h1;
            next_r.bsel  = (FORMAT_I == SAP_FMT_8) ? !r.bsel : 1'b1;
            next_r.state = SAP_SETSEL;
            tmr_load     = 1'b1;
            tmr_value    = CNT_W'(CYC_SEL_SPACE);
          end
        end
      end
      SAP_ACQ: begin
        next_r.cs_n = 1'b1;
        if (tmr_done) begin
          next_r.state = SAP_IDLE;
        end
      end
      default: begin
        next_r.state = SAP_IDLE;
      end
    endcase
  end

  always_ff @(posedge CLK_SYS_I or posedge RESET_I) begin
    if (RESET_I) begin
      r         <= '0;
      r.state   <= SAP_IDLE;
      r.start_n <= RST_START_N;
      r.cs_n    <= RST_CS_N;
      r.rd_n    <= RST_RD_N;
    end else begin
      r <= next_r;
    end
  end

  // ----------------------------------------
  // outputs, all straight from flops
  // ----------------------------------------
  assign CONVERSION_START_N_O = r.start_n;
  assign CS_N_O               = r.cs_n;
  assign RD_N_O               = r.rd_n;
  assign WORD_WIDTH_SELECT_O  = r.wsel;
  assign BYTE_SELECT_O        = r.bsel;
  assign RESULT_O             = r.result;
  assign RESULT_VALID_O       = r.valid;
  assign READY_O              = r.ready;
  assign ERROR_O              = r.error;

endmodule

// >>> include/sap_pkg.sv
// sar adc host controller package: timing constants and state encodings
// assumes a 10 MHz system clock; all pin timings are counted in its cycles
package sap_pkg;

  // ----------------------------------------
  // clock
  // ----------------------------------------
  localparam int CLK_PERIOD_NS = 100;

  // ----------------------------------------
  // converter timings in ns
  // ----------------------------------------
  localparam int T_CONV_MAX_NS     = 650;
  localparam int T_ACQ_MIN_NS      = 320;
  localparam int T_BUSY_RISE_NS    = 40;
  localparam int T_START_LOW_NS    = 40;
  localparam int T_START_HIGH_NS   = 20;
  localparam int T_HOLD_NS         = 25;
  localparam int T_FIRST_BUS_NS    = 40;
  localparam int T_RD_LOW_NS       = 50;
  localparam int T_RD_HIGH_NS      = 20;
  localparam int T_EN_NS           = 20;
  localparam int T_DIS_NS          = 20;
  localparam int T_SEL_SETUP_NS    = 10;
  localparam int T_SEL_SPACE_NS    = 50;
  localparam int T_CS_BUSY_NS      = 50;
  localparam int T_ABORT_MIN_NS    = 60;
  localparam int T_ABORT_MAX_NS    = 550;

  // ----------------------------------------
  // derived cycle counts (least times and the conversion limit round up, abort window end rounds down)
  // ----------------------------------------
  function automatic int cyc_up(input int ns);
    int c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction
  function automatic int cyc_dn(input int ns);
    int c;
    c = ns / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction

  localparam int CYC_CONV_MAX   = cyc_up(T_CONV_MAX_NS) + 1;
  localparam int CYC_ACQ        = cyc_up(T_ACQ_MIN_NS);
  localparam int CYC_START_LOW  = cyc_up(T_START_LOW_NS);
  localparam int CYC_START_HIGH = cyc_up(T_START_HIGH_NS);
  localparam int CYC_FIRST_BUS  = cyc_up(T_FIRST_BUS_NS);
  localparam int CYC_RD_LOW     = cyc_up(T_RD_LOW_NS + T_EN_NS);
  localparam int CYC_RD_HIGH    = cyc_up(T_RD_HIGH_NS + T_DIS_NS);
  localparam int CYC_SEL_SETUP  = cyc_up(T_SEL_SETUP_NS + T_EN_NS);
  localparam int CYC_SEL_SPACE  = cyc_up(T_SEL_SPACE_NS);
  localparam int CYC_CS_BUSY    = cyc_up(T_CS_BUSY_NS);
  localparam int CYC_ABORT_MIN  = cyc_up(T_ABORT_MIN_NS);
  localparam int CYC_ABORT_MAX  = cyc_dn(T_ABORT_MAX_NS);
  // edges from the start fall to the first abort test in busy
  localparam int CYC_BUSY_LEAD  = CYC_START_LOW + CYC_START_HIGH + 3;

  localparam int CNT_W = 4;

  // ----------------------------------------
  // reset values of pins
  // ----------------------------------------
  localparam logic RST_START_N = 1'b1;
  localparam logic RST_RD_N    = 1'b1;
  localparam logic RST_CS_N    = 1'b1;

  // ----------------------------------------
  // read formats
  // ----------------------------------------
  typedef enum logic [1:0] {
    SAP_FMT_18 = 2'h0,
    SAP_FMT_16 = 2'h1,
    SAP_FMT_8  = 2'h2
  } sap_fmt_t;

  // ----------------------------------------
  // sequencer states
  // ----------------------------------------
  typedef enum logic [8:0] {
    SAP_IDLE    = 9'h001,
    SAP_START   = 9'h002,
    SAP_WAITHI  = 9'h004,
    SAP_ABORT   = 9'h008,
    SAP_BUSY    = 9'h010,
    SAP_SETSEL  = 9'h020,
    SAP_RDLOW   = 9'h040,
    SAP_RDHIGH  = 9'h080,
    SAP_ACQ     = 9'h100
  } sap_state_t;

endpackage

// >>> src/sap_timer.sv
// sap_timer: loadable down counter used for every pin timing of the host except the abort window and conversion limit
// assumes load and count come from the sequencer in the same clock domain
`timescale 1ns/1ns
module sap_timer #(
  parameter int W = 4
) (
  // clock and reset
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  // control
  input  wire logic         load_i,
  input  wire logic [W-1:0] value_i,
  // status
  output logic              done_o
);

  logic [W-1:0] count;
  logic [W-1:0] next_count;

  always_comb begin
    next_count = count;
    if (load_i) begin
      next_count = value_i;
    end else if (count != '0) begin
      next_count = count - W'(1);
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      count <= '0;
    end else begin
      count <= next_count;
    end
  end

  // done is high once the loaded count has run out
  // not gated by load: the sequencer loads on done, gating would loop
  assign done_o = (count == '0);

endmodule

// >>> testbench/sap_host_props.sv
// sap_host_props: timing checks on the converter pins of the host
// assumes one clock domain; bound to sap_host below
`timescale 1ns/1ns
module sap_host_props (
  // clock and reset
  input  wire logic CLK_SYS_I,
  input  wire logic RESET_I,
  // converter pins
  input  wire logic CONVERSION_START_N_O,
  input  wire logic CS_N_O,
  input  wire logic RD_N_O,
  input  wire logic WORD_WIDTH_SELECT_O,
  input  wire logic BYTE_SELECT_O,
  input  wire logic BUSY_I
);
  // ----------------------------------------
  // helper: cycles since last start edge
  // ----------------------------------------
  logic [3:0] since_start;
  always_ff @(posedge CLK_SYS_I or posedge RESET_I) begin
    if (RESET_I) since_start <= 4'h0;
    else if ($fell(CONVERSION_START_N_O)) since_start <= 4'h1;
    else if (since_start != 4'hF) since_start <= since_start + 4'h1;
  end
  // ----------------------------------------
  // properties
  // ----------------------------------------
  default clocking @(posedge CLK_SYS_I); endclocking
  default disable iff (RESET_I);
  sequence s_busy_end; $fell(BUSY_I); endsequence
  sequence s_read_pulse; !RD_N_O && !CS_N_O ##1 !RD_N_O && !CS_N_O ##1 RD_N_O; endsequence
  property p_start_low; $fell(CONVERSION_START_N_O) |-> ##[1:2] $rose(CONVERSION_START_N_O); endproperty
  a_start_low: assert property (p_start_low) else $error("start pulse width wrong");
  property p_quiet; $fell(CONVERSION_START_N_O) |-> RD_N_O && $stable(WORD_WIDTH_SELECT_O) && $stable(BYTE_SELECT_O);
  endproperty
  a_quiet: assert property (p_quiet) else $error("bus activity too soon after start");
  property p_rd_low; $fell(RD_N_O) |-> s_read_pulse; endproperty
  a_rd_low: assert property (p_rd_low) else $error("read strobe shape wrong");
  property p_sel_setup; !$stable(BYTE_SELECT_O) || !$stable(WORD_WIDTH_SELECT_O) |-> !$fell(RD_N_O); endproperty
  a_sel_setup: assert property (p_sel_setup) else $error("select changed with read edge");
  property p_cs_busy; s_busy_end |-> !$rose(CS_N_O) ##1 !$rose(CS_N_O); endproperty
  a_cs_busy: assert property (p_cs_busy) else $error("select rise too near busy fall");
  property p_acq; s_busy_end |-> CONVERSION_START_N_O [*5]; endproperty
  a_acq: assert property (p_acq) else $error("acquisition too short");
  property p_first_read; s_busy_end |-> ##[2:3] s_read_pulse; endproperty
  a_first_read: assert property (p_first_read) else $error("read not started after busy fall");
  property p_no_rd_busy; $fell(RD_N_O) |-> !$past(BUSY_I); endproperty
  a_no_rd_busy: assert property (p_no_rd_busy) else $error("read while converting");
  // only a restart into a running conversion is an abort
  property p_abort; $fell(CONVERSION_START_N_O) && $past(BUSY_I) |-> since_start >= 4'h1 && since_start <= 4'h5;
  endproperty
  a_abort: assert property (p_abort) else $error("abort restart outside window");
endmodule
bind sap_host sap_host_props sap_host_props_i (
  .CLK_SYS_I, .RESET_I, .CONVERSION_START_N_O, .CS_N_O, .RD_N_O,
  .WORD_WIDTH_SELECT_O, .BYTE_SELECT_O, .BUSY_I
);

// >>> testbench/sap_adc_model.sv
// sap_adc_model: behavioural converter on the far side of the host
// assumes pins from sap_host; conversion time and sample set by the bench
`timescale 1ns/1ns
module sap_adc_model
  import sap_pkg::*;
(
  // host pins
  input  wire logic        conversion_start_n_i,
  input  wire logic        cs_n_i,
  input  wire logic        rd_n_i,
  input  wire logic        word_width_select_i,
  input  wire logic        byte_select_i,
  // bench control
  input  wire sap_fmt_t    fmt_i,
  input  wire logic [17:0] sample_i,
  input  wire logic [9:0]  conv_ns_i,
  // device pins
  output logic             busy_o,
  output logic [17:0]      data_o
);
  logic [17:0] held;
  logic [17:0] result;
  int          seq;
  int          rd_idx;
  wire         rd_act = !rd_n_i && !cs_n_i;
  initial begin
    busy_o = 1'b0;
    data_o = 18'h155AA;
    held = 18'h00000;
    result = 18'h00000;
    seq = 0;
    rd_idx = 0;
  end
  // ----------------------------------------
  // conversion; a new start edge supersedes a running one
  // ----------------------------------------
  always @(negedge conversion_start_n_i) begin
    seq = seq + 1;
    held = sample_i;
    fork
      begin : conv
        automatic int my = seq;
        #40 busy_o = 1'b1;
        #(conv_ns_i - 10'd40);
        if (my == seq) begin
          result = held;
          rd_idx = 0;
          busy_o = 1'b0;
        end
      end
    join_none
  end
  // ----------------------------------------
  // parallel read lanes; undriven bits show inverted junk
  // ----------------------------------------
  function automatic logic [17:0] lane();
    logic [17:0] v;
    v = ~data_o;
    if (word_width_select_i) v = result;
    else if (fmt_i == SAP_FMT_16) begin
      if (!byte_select_i) v[15:0] = result[17:2];
      else v[15:14] = result[1:0];
    end
    else if (byte_select_i) v[7:0] = result[9:2];
    else if (rd_idx == 0) v[7:0] = result[17:10];
    else v[7:6] = result[1:0];
    return v;
  endfunction
  always @(posedge rd_act) #20 data_o = lane();
  always @(word_width_select_i or byte_select_i) if (rd_act) #15 data_o = lane();
  always @(negedge rd_act) begin
    #20 data_o = ~data_o;
    rd_idx = rd_idx + 1;
  end
endmodule

// >>> testbench/sap_host_test.sv
// sap_host_test: random and corner transfers through the host and converter model
// assumes sap_pkg, sap_host, sap_adc_model and the bound checker are compiled
`timescale 1ns/1ns
module sap_host_test;
  import sap_pkg::*;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        start = 1'b0;
  logic        abort = 1'b0;
  sap_fmt_t    fmt = SAP_FMT_18;
  logic [17:0] sample = 18'h00000;
  logic [9:0]  conv_ns = 10'h28A;
  logic [17:0] result, data;
  logic        valid, ready, error, start_n, cs_n, rd_n, wsel, bsel, busy;
  int          err_total = 0;
  int          compares = 0;
  int          rd_cnt = 0;
  int          i;
  always #50 clk = ~clk;
  always @(negedge rd_n) rd_cnt++;
  sap_host sap_host_i (
    .CLK_SYS_I(clk), .RESET_I(rst), .START_I(start), .ABORT_I(abort), .FORMAT_I(fmt),
    .RESULT_O(result), .RESULT_VALID_O(valid), .READY_O(ready), .ERROR_O(error),
    .CONVERSION_START_N_O(start_n), .CS_N_O(cs_n), .RD_N_O(rd_n), .WORD_WIDTH_SELECT_O(wsel),
    .BYTE_SELECT_O(bsel), .BUSY_I(busy), .DATA_I(data));
  sap_adc_model sap_adc_model_i (
    .conversion_start_n_i(start_n), .cs_n_i(cs_n), .rd_n_i(rd_n), .word_width_select_i(wsel),
    .byte_select_i(bsel), .fmt_i(fmt), .sample_i(sample), .conv_ns_i(conv_ns), .busy_o(busy), .data_o(data));
  // ----------------------------------------
  // checking and closing
  // ----------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic close_out();
    $display("compares %0d errors %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // one transfer; abort restarts with a fresh sample mid-conversion
  task automatic run_conv(input sap_fmt_t f, input logic [17:0] smp, input logic [9:0] cns, input logic abt);
    int n;
    logic [17:0] exp;
    for (n = 0; n < 40 && ready !== 1'b1; n++) @(negedge clk);
    fmt = f; sample = smp; conv_ns = cns; start = 1'b1; rd_cnt = 0; exp = smp;
    @(negedge clk);
    start = 1'b0;
    if (abt) begin
      repeat (2) @(negedge clk);
      exp = ~smp; sample = exp; abort = 1'b1;
      for (n = 0; n < 4 && start_n !== 1'b0; n++) @(negedge clk);
      check({31'h0, start_n}, 32'h0);
      abort = 1'b0;
    end
    for (n = 0; n < 40 && valid !== 1'b1; n++) @(negedge clk);
    check({31'h0, valid}, 32'h1);
    check({14'h0, result}, {14'h0, exp});
    check(rd_cnt, (f == SAP_FMT_18) ? 1 : (f == SAP_FMT_16) ? 2 : 3);
    check({31'h0, error}, 32'h0);
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    void'($urandom(32'hA8C19EE7));
    repeat (8) @(negedge clk);
    check({29'h0, start_n, cs_n, rd_n}, 32'h7);
    check({31'h0, ready}, 32'h0);
    rst = 1'b0;
    repeat (2) @(negedge clk);
    check({31'h0, ready}, 32'h1);
    run_conv(SAP_FMT_18, 18'h3FFFF, 10'h28A, 1'b0);
    run_conv(SAP_FMT_16, 18'h20001, 10'h19A, 1'b0);
    run_conv(SAP_FMT_8, 18'h2A5A5, 10'h1F9, 1'b0);
    run_conv(SAP_FMT_18, 18'h15A5A, 10'h28A, 1'b1);
    // busy under 400 ns is flagged by the host; ends kept off the clock edges
    for (i = 0; i < 24; i++) begin
      run_conv(sap_fmt_t'($urandom_range(2)), 18'($urandom),
               (i % 6 == 5) ? 10'h28A : 10'(455 + 100 * $urandom_range(1) + $urandom_range(40)), i % 6 == 5);
    end
    @(negedge clk);
    rst = 1'b1;
    @(negedge clk);
    check({30'h0, ready, cs_n}, 32'h1);
    rst = 1'b0;
    repeat (2) @(negedge clk);
    check({31'h0, ready}, 32'h1);
    run_conv(SAP_FMT_8, 18'h00003, 10'h28A, 1'b0);
    close_out();
  end
  // hang guard: about 30 transfers of under 40 cycles each
  initial begin
    #(4000 * 100);
    err_total++;
    close_out();
  end
endmodule
